/* File: rtl/tsw_params.svh */
// Purpose: constants of the tdm switch init, pattern test and quadrant block
// Assumes: included by the package and the bench
// Notes: definitions only
`ifndef TSW_PARAMS_SVH
`define TSW_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TSW_CR_OFF      8'h00
`define TSW_IMS_OFF     8'h04
`define TSW_RXS_OFF     8'h08
`define TSW_LEN_OFF     8'h0C
`define TSW_ERR_OFF     8'h10
`define TSW_ISC_OFF     8'h14
`define TSW_CMA_OFF     8'h18
`define TSW_CMD_OFF     8'h1C
`define TSW_STAT_OFF    8'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define TSW_CR_EN       0
`define TSW_CR_RUN      1
`define TSW_CR_CLR      2
`define TSW_IMS_START   0
`define TSW_IMS_PAT     1
`define TSW_LEN_TXS     8
// ----------------------------------------
// memory, codes and timing
// ----------------------------------------
`define TSW_CM_WORDS    512
`define TSW_CM_LAST     9'h1FF
`define TSW_CM_BER      3'h7
`define TSW_PRBS_SEED   15'h7FFF
`define TSW_ERR_MAX     16'hFFFF
`define TSW_RATE_MAX    2'h2
`define TSW_LSB_POS     3'h7
`define TSW_FILL_NS     50000
`define TSW_CLK_NS      4
`define TSW_RESP_OK     2'h0
`define TSW_RESP_ERR    2'h2
`endif

/* File: rtl/tsw_pkg.sv */
// Purpose: types shared by the tdm switch block
// Assumes: tsw_params.svh on the include path
// Notes: the register state of the top is one packed struct; the connection memory is separate
`include "tsw_params.svh"
package tsw_pkg;
	typedef enum logic {TSW_IDLE, TSW_FILL} tsw_fill_e;
	typedef struct packed {
		logic        cr_en;
		logic        cr_run;
		logic        cr_clr;
		logic        ims_start;
		logic [2:0]  ims_pat;
		logic [6:0]  rx_ch;
		logic [3:0]  rx_stm;
		logic [7:0]  len;
		logic [1:0]  tx_stm;
		logic [3:0]  qen;
		logic [1:0]  rate;
		logic [8:0]  cm_addr;
		logic [15:0] err;
		tsw_fill_e   fsm;
		logic [8:0]  fill_addr;
		logic        awready;
		logic        wready;
		logic        aw_have;
		logic        w_have;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        lclk_d;
		logic [2:0]  bit_cnt;
		logic [6:0]  ch;
		logic        tx_bit;
		logic [7:0]  rx_sh;
		logic [7:0]  rx_byte;
		logic        rx_vld;
		logic [14:0] gen;
		logic [14:0] chk;
	} tsw_state_s;
endpackage

/* File: rtl/tsw_lfsr_if.sv */
// Purpose: carries one prbs register between the top and its step logic
// Assumes: nothing
// Notes: feed_sel picks self-sync feed for the checker
`timescale 1ns/1ps
interface tsw_lfsr_if;
	logic [14:0] cur;
	logic        feed_sel;
	logic        feed_bit;
	logic [14:0] nxt;
	logic        tap;
	modport user (output cur, output feed_sel, output feed_bit, input nxt, input tap);
	modport core (input cur, input feed_sel, input feed_bit, output nxt, output tap);
endinterface

/* File: rtl/tsw_prbs.sv */
// Purpose: one step of the 2^15-1 sequence, x^15 + x^14 + 1
// Assumes: register held by the user side
// Notes: purely combinational
`timescale 1ns/1ps
module tsw_prbs (
	tsw_lfsr_if.core p
);
	assign p.tap = p.cur[14] ^ p.cur[13];
	assign p.nxt = {p.cur[13:0], p.feed_sel ? p.feed_bit : p.tap};
endmodule

/* File: rtl/tsw_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_in
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module tsw_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	if (W < 1) $error("tsw_sync: width must be at least one");
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

/* File: rtl/tsw_top.sv */
// Purpose: block fill of connection memory, pattern test, quadrant lsb force
// Assumes: axi4-lite master, link clock sampled by clk_in, one stream each way
// Notes: connection memory address is {tx stream, channel}
`timescale 1ns/1ps
module tsw_top
	import tsw_pkg::*;
#(
	parameter int AW            = 8,
	parameter int FILL_LIMIT_CY = `TSW_FILL_NS / `TSW_CLK_NS
) (
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          link_clk_in,
	input  wire logic          frame_in,
	input  wire logic          serial_in_stream_in,
	output logic               serial_out_stream_out,
	output logic [7:0]         rx_byte_out,
	output logic               rx_byte_valid_out
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (AW < 8) $error("tsw_top: address width below 8");
	if (FILL_LIMIT_CY < `TSW_CM_WORDS) $error("tsw_top: fill cannot meet its limit");

	// ----------------------------------------
	// state, memory, synchronisers
	// ----------------------------------------
	tsw_state_s  st;
	tsw_state_s  n;
	logic [11:0] cm_mem [`TSW_CM_WORDS];
	logic        mem_we;
	logic [8:0]  mem_wa;
	logic [11:0] mem_wd;
	logic [2:0]  sync_q;
	logic        lclk_s;
	logic        frm_s;
	logic        si_s;
	logic        lk_edge;
	logic [1:0]  rate_c;
	logic [6:0]  ch_last;
	logic [2:0]  pos_bit;
	logic [6:0]  pos_ch;
	logic [1:0]  quad;
	logic        rx_b;
	logic        in_win;
	logic [11:0] tx_word;
	logic        ber_ch;
	logic [32:0] rd_v;
	logic [31:0] wv;

	tsw_sync #(.W(3)) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({link_clk_in, frame_in, serial_in_stream_in}),
		.q_out  (sync_q)
	);
	assign {lclk_s, frm_s, si_s} = sync_q;

	tsw_lfsr_if gen_if ();
	tsw_lfsr_if chk_if ();
	tsw_prbs u_gen (.p(gen_if));
	tsw_prbs u_chk (.p(chk_if));

	// ----------------------------------------
	// frame position and datapath terms
	// ----------------------------------------
	// rate code 3 is treated as 8 Mbps
	assign rate_c  = (st.rate > `TSW_RATE_MAX) ? `TSW_RATE_MAX : st.rate;
	assign ch_last = 7'((8'h20 << rate_c) - 8'h01);
	assign lk_edge = lclk_s & ~st.lclk_d;
	assign pos_bit = frm_s ? 3'h0 : 3'(st.bit_cnt + 3'h1);
	assign pos_ch  = frm_s ? 7'h00 :
		(st.bit_cnt != `TSW_LSB_POS) ? st.ch :
		(st.ch == ch_last) ? 7'h00 : 7'(st.ch + 7'h01);
	assign quad    = 2'(pos_ch >> (3'h3 + 3'(rate_c)));
	assign rx_b    = ((pos_bit == `TSW_LSB_POS) && st.qen[quad]) ? 1'b1 : si_s;
	assign in_win  = (pos_ch >= st.rx_ch) &&
		({2'h0, pos_ch} < ({2'h0, st.rx_ch} + {1'b0, st.len}));
	assign tx_word = cm_mem[{st.tx_stm, pos_ch}];
	assign ber_ch  = (tx_word[2:0] == `TSW_CM_BER);

	assign gen_if.cur      = st.gen;
	assign gen_if.feed_sel = 1'b0;
	assign gen_if.feed_bit = 1'b0;
	assign chk_if.cur      = st.chk;
	assign chk_if.feed_sel = 1'b1;
	assign chk_if.feed_bit = rx_b;

	// ----------------------------------------
	// register read mux, bit 32 flags unmapped
	// ----------------------------------------
	function automatic logic [32:0] rd_mux(input tsw_state_s s, input logic [11:0] cmw,
			input logic [7:0] a);
		logic [32:0] r;
		r = '0;
		case (a)
			`TSW_CR_OFF:   r[2:0]  = {s.cr_clr, s.cr_run, s.cr_en};
			`TSW_IMS_OFF:  r[3:0]  = {s.ims_pat, s.ims_start};
			`TSW_RXS_OFF:  r[10:0] = {s.rx_stm, s.rx_ch};
			`TSW_LEN_OFF:  r[9:0]  = {s.tx_stm, s.len};
			`TSW_ERR_OFF:  r[15:0] = s.err;
			`TSW_ISC_OFF:  r[5:0]  = {s.rate, s.qen};
			`TSW_CMA_OFF:  r[8:0]  = s.cm_addr;
			`TSW_CMD_OFF:  r[11:0] = cmw;
			`TSW_STAT_OFF: r[0]    = (s.fsm == TSW_FILL);
			default:       r[32]   = 1'b1;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] v,
			input logic [3:0] sb);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (sb[i]) begin
				r[8*i +: 8] = v[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign rd_v = rd_mux(st, cm_mem[st.cm_addr], 8'(s_axi_araddr));
	assign wv   = wmerge(32'(rd_mux(st, cm_mem[st.cm_addr], st.awaddr)), st.wdata, st.wstrb);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		n      = st;
		mem_we = 1'b0;
		mem_wa = st.fill_addr;
		mem_wd = {9'h000, st.ims_pat};
		n.rx_vld = 1'b0;
		n.lclk_d = lclk_s;

		// link side, one bit per link clock rising edge
		if (lk_edge) begin
			n.bit_cnt = pos_bit;
			n.ch      = pos_ch;
			n.rx_sh   = {st.rx_sh[6:0], rx_b};
			if (pos_bit == `TSW_LSB_POS) begin
				n.rx_byte = {st.rx_sh[6:0], rx_b};
				n.rx_vld  = 1'b1;
			end
			if (st.cr_run && ber_ch) begin
				n.tx_bit = gen_if.tap;
				n.gen    = gen_if.nxt;
			end else begin
				n.tx_bit = 1'b1;
			end
			if (st.cr_run && in_win) begin
				n.chk = chk_if.nxt;
				if ((rx_b != chk_if.tap) && (st.err != `TSW_ERR_MAX)) begin
					n.err = 16'(st.err + 16'h0001);
				end
			end
		end
		if (!st.cr_run) begin
			n.tx_bit = 1'b1;
			n.gen = `TSW_PRBS_SEED;
			n.chk = `TSW_PRBS_SEED;
		end
		if (st.cr_clr) begin
			n.err = '0;
		end

		// block fill, one word per clock
		case (st.fsm)
			TSW_IDLE: begin
				if (st.ims_start && st.cr_en) begin
					n.fsm       = TSW_FILL;
					n.fill_addr = '0;
				end
			end
			TSW_FILL: begin
				if (!st.ims_start || !st.cr_en) begin
					n.fsm = TSW_IDLE;
				end else begin
					mem_we = 1'b1;
					if (st.fill_addr == `TSW_CM_LAST) begin
						n.fsm       = TSW_IDLE;
						n.ims_start = 1'b0;
					end else begin
						n.fill_addr = 9'(st.fill_addr + 9'h001);
					end
				end
			end
			default: n.fsm = TSW_IDLE;
		endcase

		// axi4-lite write; host write after fill so a host set wins
		if (s_axi_awvalid && st.awready) begin
			n.aw_have = 1'b1;
			n.awaddr  = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && st.wready) begin
			n.w_have = 1'b1;
			n.wdata  = s_axi_wdata;
			n.wstrb  = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (st.aw_have && st.w_have && !st.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = `TSW_RESP_OK;
			case (st.awaddr)
				`TSW_CR_OFF: begin
					n.cr_en  = wv[`TSW_CR_EN];
					n.cr_run = wv[`TSW_CR_RUN];
					n.cr_clr = wv[`TSW_CR_CLR];
				end
				`TSW_IMS_OFF: begin
					n.ims_start = wv[`TSW_IMS_START];
					n.ims_pat   = wv[`TSW_IMS_PAT +: 3];
				end
				`TSW_RXS_OFF: {n.rx_stm, n.rx_ch} = wv[10:0];
				`TSW_LEN_OFF: begin
					n.len    = wv[7:0];
					n.tx_stm = wv[`TSW_LEN_TXS +: 2];
				end
				`TSW_ISC_OFF: {n.rate, n.qen} = wv[5:0];
				`TSW_CMA_OFF: n.cm_addr = wv[8:0];
				`TSW_CMD_OFF: begin
					// fill owns the memory while it runs
					if (st.fsm == TSW_IDLE) begin
						mem_we = 1'b1;
						mem_wa = st.cm_addr;
						mem_wd = wv[11:0];
					end
				end
				`TSW_ERR_OFF, `TSW_STAT_OFF: ;
				default: n.bresp = `TSW_RESP_ERR;
			endcase
		end
		n.awready = !n.aw_have && !n.bvalid;
		n.wready  = !n.w_have && !n.bvalid;

		// axi4-lite read, answered on the edge that takes the address
		if (st.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_v[31:0];
			n.rresp  = rd_v[32] ? `TSW_RESP_ERR : `TSW_RESP_OK;
		end
		n.arready = !n.rvalid;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st         <= '0;
			st.fsm     <= TSW_IDLE;
			st.bit_cnt <= `TSW_LSB_POS;
			st.tx_bit  <= 1'b1;
			st.gen     <= `TSW_PRBS_SEED;
			st.chk     <= `TSW_PRBS_SEED;
			st.awready <= 1'b1;
			st.wready  <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// memory has no reset; block fill initialises it
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			cm_mem[mem_wa] <= mem_wd;
		end
	end

	assign s_axi_awready         = st.awready;
	assign s_axi_wready          = st.wready;
	assign s_axi_bvalid          = st.bvalid;
	assign s_axi_bresp           = st.bresp;
	assign s_axi_arready         = st.arready;
	assign s_axi_rvalid          = st.rvalid;
	assign s_axi_rresp           = st.rresp;
	assign s_axi_rdata           = st.rdata;
	assign serial_out_stream_out = st.tx_bit;
	assign rx_byte_out           = st.rx_byte;
	assign rx_byte_valid_out     = st.rx_vld;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_fill_word;
		(st.fsm == TSW_FILL) && st.ims_start && st.cr_en |=>
			cm_mem[$past(st.fill_addr)] == {9'h000, $past(st.ims_pat)};
	endproperty
	a_fill_word: assert property (p_fill_word) else $error("fill word wrong");

	property p_fill_time;
		$rose(st.fsm == TSW_FILL) |-> ##[1:513] (st.fsm == TSW_IDLE);
	endproperty
	a_fill_time: assert property (p_fill_time) else $error("fill too long");

	property p_fill_done;
		(st.fsm == TSW_FILL) && st.ims_start && st.cr_en && (st.fill_addr == `TSW_CM_LAST)
			&& !(st.aw_have && st.w_have && !st.bvalid && st.awaddr == `TSW_IMS_OFF)
			|=> !st.ims_start && (st.fsm == TSW_IDLE);
	endproperty
	a_fill_done: assert property (p_fill_done) else $error("start not cleared");

	property p_abort;
		(st.fsm == TSW_FILL) && (!st.cr_en || !st.ims_start) |=> (st.fsm == TSW_IDLE);
	endproperty
	a_abort: assert property (p_abort) else $error("fill not aborted");

	property p_ber_tx;
		lk_edge && !ber_ch |=> serial_out_stream_out;
	endproperty
	a_ber_tx: assert property (p_ber_tx) else $error("non-test channel driven");

	property p_run_stop;
		!st.cr_run |=> (st.gen == `TSW_PRBS_SEED) && (st.chk == `TSW_PRBS_SEED);
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("prbs not held");

	property p_clear;
		st.cr_clr |=> (st.err == 16'h0000);
	endproperty
	a_clear: assert property (p_clear) else $error("count not cleared");

	property p_sat;
		(st.err == `TSW_ERR_MAX) && !st.cr_clr |=> (st.err == `TSW_ERR_MAX);
	endproperty
	a_sat: assert property (p_sat) else $error("count wrapped");

	property p_ones;
		!st.cr_run && !$past(st.cr_run) |-> serial_out_stream_out;
	endproperty
	a_ones: assert property (p_ones) else $error("output not all ones");

	property p_quad;
		lk_edge && (pos_bit == `TSW_LSB_POS) && st.qen[quad] |=> rx_byte_out[0] && rx_byte_valid_out;
	endproperty
	a_quad: assert property (p_quad) else $error("lsb not forced");

	property p_err_inc;
		lk_edge && st.cr_run && in_win && (rx_b != chk_if.tap) && !st.cr_clr
			&& (st.err != `TSW_ERR_MAX) |=> (st.err == $past(st.err) + 16'h0001);
	endproperty
	a_err_inc: assert property (p_err_inc) else $error("error not counted");

	c_fill_done: cover property ($fell(st.ims_start) && (st.fsm == TSW_IDLE) && st.cr_en);
	c_err_seen:  cover property ($changed(st.err) && (st.err != 16'h0000));
	c_quad_hit:  cover property (rx_byte_valid_out && (st.qen != 4'h0));
	c_saturate:  cover property (st.err == `TSW_ERR_MAX);
endmodule

/* File: bench/tsw_link_model.sv */
// Purpose: far-end tdm device: link clock, frame pulse, serial input stream
// Assumes: 32 channels of 8 bits a frame, bit 7 first, data moves on falling edge
// Notes: loop mode returns each output bit one frame later in the same slot
`timescale 1ns/1ps
module tsw_link_model (
	input  wire logic       loop_in,
	input  wire logic       flip_in,
	input  wire logic [7:0] byte_in,
	input  wire logic       tx_line_in,
	output logic            link_clk_out,
	output logic            frame_out,
	output logic            rx_line_out,
	output logic [7:0]      sent_out,
	output logic [4:0]      ch_out,
	output logic            done_out
);
	logic [255:0] mem_r;
	logic [7:0]   pos_r;
	logic [7:0]   sh_r;
	// ----------------------------------------
	// bit clock runs free, as a backplane clock does
	// ----------------------------------------
	initial begin
		link_clk_out = 1'b0;
		frame_out = 1'b0;
		rx_line_out = 1'b1;
		done_out = 1'b0;
		sent_out = 8'h00;
		ch_out = 5'h00;
		sh_r = 8'hFF;
		pos_r = 8'hFF;
		mem_r = '1;
		forever begin
			#62.5 link_clk_out = ~link_clk_out;
		end
	end
	always @(negedge link_clk_out) begin
		mem_r[pos_r] = tx_line_in;
		pos_r = pos_r + 8'h01;
		if (pos_r[2:0] == 3'h0) begin
			sh_r = byte_in;
			sent_out = byte_in;
			ch_out = pos_r[7:3];
			done_out = ~done_out;
		end
		frame_out = (pos_r == 8'h00);
		// a whole frame of delay keeps each returned bit in its own channel
		rx_line_out = loop_in ? (mem_r[pos_r] ^ flip_in) : sh_r[3'h7 - pos_r[2:0]];
	end
endmodule

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for fill, pattern test and quadrant forcing
// Assumes: 32 model channels, rate 0 except one quadrant pass at rate 2, one input and one output stream
// Notes: rx bytes go through a queue of expected values
`timescale 1ns/1ps
`include "tsw_params.svh"
module tb_top;
	localparam int FRM = 8000;
	logic        clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready, loop, flip;
	logic [7:0]  awaddr, araddr, tbyte;
	logic [31:0] wdata, rnd, rd, e;
	logic [1:0]  rsp;
	logic [2:0]  pat;
	logic [3:0]  qen;
	logic [1:0]  rt;
	logic        sb_on;
	logic [31:0] expq[$];
	int          mismatches, samples_checked, z;
	wire logic        awready, wready, bvalid, arready, rvalid, sout, lclk, frm, sin, rxv, mdone;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  rxb, sent;
	wire logic [4:0]  mch;
	tsw_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link_clk_in(lclk), .frame_in(frm),
		.serial_in_stream_in(sin), .serial_out_stream_out(sout),
		.rx_byte_out(rxb), .rx_byte_valid_out(rxv));
	tsw_link_model mdl_u (.loop_in(loop), .flip_in(flip), .byte_in(tbyte),
		.tx_line_in(sout), .link_clk_out(lclk), .frame_out(frm), .rx_line_out(sin),
		.sent_out(sent), .ch_out(mch), .done_out(mdone));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic final_report;
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic stall;
		mismatches++;
		final_report();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (n > 200) stall();
		end while (!(bvalid && bready));
		bready <= 1'b0;
		rsp = bresp;
	endtask
	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (n > 200) stall();
		end while (!(rvalid && rready));
		rready <= 1'b0;
		rd = rdata;
		rsp = rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		rdr(a);
		chk(rd, x);
	endtask
	task automatic cmchk(input logic [8:0] a, input logic [11:0] x);
		wr(`TSW_CMA_OFF, {23'h0, a});
		rchk(`TSW_CMD_OFF, {20'h0, x});
	endtask
	task automatic fill(input logic [2:0] p);
		time t0;
		int  n;
		n = 0;
		wr(`TSW_IMS_OFF, {28'h0, p, 1'b0});
		wr(`TSW_CR_OFF, 32'h1);
		wr(`TSW_IMS_OFF, {28'h0, p, 1'b1});
		t0 = $time;
		do begin
			rdr(`TSW_IMS_OFF);
			n++;
			if (n > 5000) stall();
		end while (rd[0] !== 1'b0);
		chk({31'h0, ($time - t0) <= 50000}, 32'h1);
		chk(rd, {28'h0, p, 1'b0});
		wr(`TSW_CR_OFF, 32'h0);
	endtask
	task automatic zeros(input int cy);
		z = 0;
		repeat (cy) begin
			@(posedge clk_in);
			if (sout !== 1'b1) z++;
		end
	endtask
	task automatic hit_ch5;
		while (mch !== 5'h05) @(mdone);
		@(posedge clk_in);
		flip <= 1'b1;
		@(negedge lclk);
		@(posedge clk_in);
		flip <= 1'b0;
	endtask
	// ----------------------------------------
	// clock, watchdog, scoreboard
	// ----------------------------------------
	always #2 clk_in = ~clk_in;
	initial begin
		#390000;
		stall();
	end
	always @(mdone) begin
		if (sb_on) expq.push_back({24'h0, sent | {7'h00, qen[2'(mch >> (3 + rt))]}});
		@(posedge clk_in);
		rnd = xs(rnd);
		tbyte <= rnd[7:0];
	end
	always @(posedge clk_in) begin
		if (rxv === 1'b1 && expq.size() > 0) chk({24'h0, rxb}, expq.pop_front());
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		rst_in = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, loop, flip, sb_on} = 8'h00;
		{awaddr, araddr, tbyte, wdata} = 56'h0;
		mismatches = 0;
		samples_checked = 0;
		rnd = 32'h7C82;
		qen = 4'h0;
		rt = 2'h0;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		rchk(`TSW_ERR_OFF, 32'h0);
		rdr(8'h40);
		chk({30'h0, rsp}, {30'h0, `TSW_RESP_ERR});
		wr(`TSW_CMA_OFF, 32'h1FF);
		wr(8'h40, 32'h0);
		chk({30'h0, rsp}, {30'h0, `TSW_RESP_ERR});
		wr(`TSW_CMD_OFF, 32'hFFFF_FFFF);
		chk({30'h0, rsp}, {30'h0, `TSW_RESP_OK});
		rchk(`TSW_CMD_OFF, 32'hFFF);
		rnd = xs(rnd);
		pat = rnd[2:0];
		fill(pat);
		cmchk(9'h000, {9'h0, pat});
		cmchk(rnd[12:4], {9'h0, pat});
		cmchk(9'h1FF, {9'h0, pat});
		wr(`TSW_CMD_OFF, 32'hFFF);
		wr(`TSW_CR_OFF, 32'h1);
		wr(`TSW_IMS_OFF, {28'h0, ~pat, 1'b1});
		wr(`TSW_IMS_OFF, {28'h0, ~pat, 1'b0});
		rchk(`TSW_STAT_OFF, 32'h0);
		wr(`TSW_IMS_OFF, {28'h0, ~pat, 1'b1});
		wr(`TSW_CR_OFF, 32'h0);
		rchk(`TSW_STAT_OFF, 32'h0);
		wr(`TSW_IMS_OFF, 32'h0);
		cmchk(9'h1FF, 12'hFFF);
		cmchk(9'h000, {9'h0, ~pat});
		// 2 Mb/s: quadrant 0 forced, 1 left alone; then 8 Mb/s, where
		// all 32 model channels sit in quadrant 0, which is left alone
		for (int q = 0; q < 2; q++) begin
			rt = (q == 0) ? 2'h0 : `TSW_RATE_MAX;
			qen = (q == 0) ? ((rnd[3:0] | 4'h1) & 4'hD) : 4'hE;
			wr(`TSW_ISC_OFF, {26'h0, rt, qen});
			sb_on = 1'b1;
			repeat (24) @(mdone);
			sb_on = 1'b0;
			repeat (2) @(mdone);
			chk(32'(expq.size()), 32'h0);
		end
		wr(`TSW_ISC_OFF, 32'h0);
		fill(`TSW_CM_BER);
		zeros(2000);
		chk(32'(z), 32'h0);
		wr(`TSW_CR_OFF, 32'h2);
		zeros(2000);
		chk({31'h0, z > 0}, 32'h1);
		wr(`TSW_CR_OFF, 32'h0);
		fill(3'h0);
		wr(`TSW_CR_OFF, 32'h2);
		zeros(FRM);
		chk(32'(z), 32'h0);
		wr(`TSW_CR_OFF, 32'h0);
		for (int c = 4; c < 12; c++) begin
			wr(`TSW_CMA_OFF, 32'(c));
			wr(`TSW_CMD_OFF, {29'h0, `TSW_CM_BER});
		end
		wr(`TSW_RXS_OFF, 32'h4);
		wr(`TSW_LEN_OFF, 32'h8);
		loop = 1'b1;
		wr(`TSW_CR_OFF, 32'h2);
		repeat (3 * FRM) @(posedge clk_in);
		wr(`TSW_CR_OFF, 32'h6);
		wr(`TSW_CR_OFF, 32'h2);
		repeat (FRM) @(posedge clk_in);
		rchk(`TSW_ERR_OFF, 32'h0);
		hit_ch5();
		repeat (FRM) @(posedge clk_in);
		rdr(`TSW_ERR_OFF);
		chk({31'h0, rd !== 32'h0}, 32'h1);
		e = rd;
		wr(`TSW_CR_OFF, 32'h0);
		hit_ch5();
		repeat (FRM) @(posedge clk_in);
		rchk(`TSW_ERR_OFF, e);
		wr(`TSW_CR_OFF, 32'h4);
		rchk(`TSW_ERR_OFF, 32'h0);
		wr(`TSW_CR_OFF, 32'h0);
		final_report();
	end
endmodule
